//--- rtl/eet_pkg.sv
// Purpose: Constants for the ECC fault trap and error tally block
// Assumes: 32-bit register port, one word per register
// Notes:   Offsets are byte addresses on the plain register port
package eet_pkg;
    localparam int          EET_ADDR_W       = 8;
    localparam int          EET_DATA_W       = 32;
    localparam int          EET_TRAP_W       = 32;
    localparam int          EET_TALLY_W      = 16;
    localparam int          EET_UNIT_BYTES   = 16;
    localparam int          EET_UNIT_LSB     = 4;
    localparam logic [7:0]  EET_OFS_TRAP     = 8'h00;
    localparam logic [7:0]  EET_OFS_TALLY    = 8'h04;
    localparam logic [7:0]  EET_OFS_CTRL     = 8'h08;
    localparam logic [7:0]  EET_OFS_STATUS   = 8'h0c;
    localparam logic [7:0]  EET_OFS_MASK     = 8'h10;
    localparam logic [31:0] EET_TRAP_RST     = 32'h0000_0000;
    localparam logic [15:0] EET_TALLY_RST    = 16'h0000;
    localparam logic [15:0] EET_TALLY_MAX    = 16'hffff;
    localparam logic [15:0] EET_TALLY_ONE    = 16'h0001;
    localparam logic [31:0] EET_RD_UNMAPPED  = 32'h0000_0000;
    localparam int          EET_CTRL_BOTH    = 0;
    localparam int          EET_IRQ_W        = 3;
    localparam int          EET_IRQ_CAPTURE  = 0;
    localparam int          EET_IRQ_COUNT    = 1;
    localparam int          EET_IRQ_SAT      = 2;
    localparam logic [2:0]  EET_IRQ_RST      = 3'h0;
endpackage

//--- rtl/eet_trap_tally.sv
// Purpose: ECC fault address trap and saturating error tally for array reads
// Assumes: Inputs synchronous to CLK; one UNIT_ERR pulse per errored unit per read
// Notes:   Registers are read-only to software apart from control and mask
//
// Summary of operation
// R1: The trap keeps the unit address of the first ECC error after a clear and ignores later ones.
// R2: The trap loads only while an array read instruction is executing.
// R3: Software masks address bits above the device density before using the trap value.
// R4: The trap returns to zero on clear-ECC-status and on any reset.
// R5: Trap and tally count single and double errors, or single errors only, as selected.
// R6: A 16-bit tally counts ECC errors seen in array reads since the last reset.
// R7: The tally changes only while an array read instruction is executing.
// R8: Each errored unit read adds at most one, and each new read of it adds one again.
// R9: The tally holds at its maximum instead of wrapping.
// R10: The tally returns to zero on any reset.
// R11: Addresses and counting refer to sixteen-byte aligned data units.
// R12: Software writes to the trap and tally are ignored.
`timescale 1ns/1ps
module eet_trap_tally
    import eet_pkg::*;
(
    input  wire logic                  CLK,
    input  wire logic                  RST,
    input  wire logic                  READ_ACTIVE,
    input  wire logic                  UNIT_ERR,
    input  wire logic                  UNIT_ERR_2BIT,
    input  wire logic [EET_TRAP_W-1:0] UNIT_ADDR,
    input  wire logic                  CLEAR_ECC_STATUS,
    input  wire logic [EET_ADDR_W-1:0] REG_ADDR,
    input  wire logic [EET_DATA_W-1:0] REG_WDATA,
    input  wire logic                  REG_WR,
    input  wire logic                  REG_RD,
    output logic      [EET_DATA_W-1:0] REG_RDATA,
    output logic                       IRQ
);

    logic [EET_TRAP_W-1:0]  trap_r;
    logic                   trap_full_r;
    logic [EET_TALLY_W-1:0] tally_r;
    logic                   both_r;
    logic [EET_IRQ_W-1:0]   status_r;
    logic [EET_IRQ_W-1:0]   mask_r;
    logic                   err_hit;
    logic                   capture;
    logic                   count;
    logic                   sat_hit;
    logic [EET_IRQ_W-1:0]   event_vec;
    logic                   rd_status;
    logic [EET_DATA_W-1:0]  rdata_nxt;
    logic [EET_IRQ_W-1:0]   status_nxt;

    function automatic logic hit(input logic [EET_ADDR_W-1:0] a, input logic [EET_ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    // Double-bit errors are dropped when only single-bit reporting is selected
    assign err_hit   = UNIT_ERR && (both_r || !UNIT_ERR_2BIT); // R5
    assign capture   = READ_ACTIVE && err_hit && !trap_full_r; // R1 R2
    assign count     = READ_ACTIVE && err_hit && (tally_r != EET_TALLY_MAX); // R7 R8 R9
    assign sat_hit   = count && (tally_r == (EET_TALLY_MAX - EET_TALLY_ONE));
    assign event_vec = {sat_hit, count, capture};
    assign rd_status = REG_RD && hit(REG_ADDR, EET_OFS_STATUS);
    // Next status feeds IRQ too, so the interrupt follows status with no extra cycle
    assign status_nxt = (rd_status ? EET_IRQ_RST : status_r) | event_vec;

    // Low bits are forced to zero so the trap always names a whole unit
    always_ff @(posedge CLK) begin
        if (RST || CLEAR_ECC_STATUS) begin // R4
            trap_r      <= EET_TRAP_RST;
            trap_full_r <= 1'b0;
        end else if (capture) begin // R1 R2
            trap_r      <= {UNIT_ADDR[EET_TRAP_W-1:EET_UNIT_LSB], {EET_UNIT_LSB{1'b0}}}; // R11
            trap_full_r <= 1'b1;
        end
    end

    // Clear-ECC-status leaves the tally alone; only reset zeroes it
    always_ff @(posedge CLK) begin
        if (RST) begin
            tally_r <= EET_TALLY_RST; // R10
        end else if (count) begin
            tally_r <= tally_r + EET_TALLY_ONE; // R6 R8 R9
        end
    end

    // Reporting select resets to both kinds so nothing is missed before software sets it up
    always_ff @(posedge CLK) begin
        if (RST) begin
            both_r <= 1'b1;
        end else if (REG_WR && hit(REG_ADDR, EET_OFS_CTRL)) begin
            both_r <= REG_WDATA[EET_CTRL_BOTH]; // R5
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            mask_r <= EET_IRQ_RST;
        end else if (REG_WR && hit(REG_ADDR, EET_OFS_MASK)) begin
            mask_r <= REG_WDATA[EET_IRQ_W-1:0];
        end
    end

    // A new event in the same cycle as the clearing read stays set
    for (genvar g = 0; g < EET_IRQ_W; g++) begin : g_status
        always_ff @(posedge CLK) begin
            if (RST) begin
                status_r[g] <= EET_IRQ_RST[g];
            end else begin
                status_r[g] <= status_nxt[g];
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(status_nxt & mask_r);
        end
    end

    // Writes to trap and tally offsets fall through with no effect
    always_comb begin
        rdata_nxt = EET_RD_UNMAPPED; // R12
        unique case (REG_ADDR)
            EET_OFS_TRAP:   rdata_nxt = trap_r;
            EET_OFS_TALLY:  rdata_nxt = {{(EET_DATA_W-EET_TALLY_W){1'b0}}, tally_r};
            EET_OFS_CTRL:   rdata_nxt = {{(EET_DATA_W-1){1'b0}}, both_r};
            EET_OFS_STATUS: rdata_nxt = {{(EET_DATA_W-EET_IRQ_W){1'b0}}, status_r};
            EET_OFS_MASK:   rdata_nxt = {{(EET_DATA_W-EET_IRQ_W){1'b0}}, mask_r};
            default:        rdata_nxt = EET_RD_UNMAPPED;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            REG_RDATA <= EET_RD_UNMAPPED;
        end else if (REG_RD) begin
            REG_RDATA <= rdata_nxt;
        end else begin
            REG_RDATA <= EET_RD_UNMAPPED;
        end
    end

    trap_first_a: assert property (@(posedge CLK) disable iff (RST) // R1
        trap_full_r && !CLEAR_ECC_STATUS |=> $stable(trap_r))
        else $error("trap changed while holding a capture");

    trap_read_only_a: assert property (@(posedge CLK) disable iff (RST) // R2
        !READ_ACTIVE && !CLEAR_ECC_STATUS |=> $stable(trap_r) && $stable(trap_full_r))
        else $error("trap changed outside an array read");

    trap_clear_a: assert property (@(posedge CLK) // R4
        CLEAR_ECC_STATUS || RST |=> trap_r == EET_TRAP_RST && !trap_full_r)
        else $error("trap not zero after clear");

    sequence single_err_s;
        READ_ACTIVE && UNIT_ERR && !UNIT_ERR_2BIT && !trap_full_r && !CLEAR_ECC_STATUS;
    endsequence
    trap_capture_a: assert property (@(posedge CLK) disable iff (RST) // R1 R11
        single_err_s |=> trap_r == {$past(UNIT_ADDR[EET_TRAP_W-1:EET_UNIT_LSB]), {EET_UNIT_LSB{1'b0}}})
        else $error("trap missed the first single-bit error");

    filter_2bit_a: assert property (@(posedge CLK) disable iff (RST) // R5
        !both_r && UNIT_ERR_2BIT |=> $stable(tally_r))
        else $error("double-bit error counted while filtered");

    tally_read_only_a: assert property (@(posedge CLK) disable iff (RST) // R7
        !READ_ACTIVE |=> $stable(tally_r))
        else $error("tally changed outside an array read");

    tally_step_a: assert property (@(posedge CLK) disable iff (RST) // R8
        READ_ACTIVE && err_hit && tally_r != EET_TALLY_MAX |=> tally_r == $past(tally_r) + EET_TALLY_ONE)
        else $error("tally did not step by one");

    tally_sat_a: assert property (@(posedge CLK) disable iff (RST) // R9
        tally_r == EET_TALLY_MAX |=> tally_r == EET_TALLY_MAX)
        else $error("tally wrapped past its maximum");

    tally_reset_a: assert property (@(posedge CLK) // R10
        RST |=> tally_r == EET_TALLY_RST)
        else $error("tally not zero after reset");

    tally_keep_a: assert property (@(posedge CLK) disable iff (RST) // R6 R12
        REG_WR && !READ_ACTIVE |=> $stable(tally_r) && $stable(trap_r) || $past(CLEAR_ECC_STATUS))
        else $error("software write altered trap or tally");

    // Register port checks
    sequence trap_read_s;
        REG_RD && hit(REG_ADDR, EET_OFS_TRAP);
    endsequence

    sequence tally_read_s;
        REG_RD && hit(REG_ADDR, EET_OFS_TALLY);
    endsequence

    sequence status_read_s;
        REG_RD && hit(REG_ADDR, EET_OFS_STATUS);
    endsequence

    sequence taken_err_s;
        READ_ACTIVE && err_hit;
    endsequence

    rdata_idle_a: assert property (@(posedge CLK) disable iff (RST) // R12
        !REG_RD |=> REG_RDATA == EET_RD_UNMAPPED)
        else $error("read data not zero outside a read");

    rdata_trap_a: assert property (@(posedge CLK) disable iff (RST) // R1
        trap_read_s |=> REG_RDATA == $past(trap_r))
        else $error("trap read returned wrong data");

    rdata_tally_a: assert property (@(posedge CLK) disable iff (RST) // R6
        tally_read_s |=> REG_RDATA == {{(EET_DATA_W-EET_TALLY_W){1'b0}}, $past(tally_r)})
        else $error("tally read returned wrong data");

    rdata_status_a: assert property (@(posedge CLK) disable iff (RST)
        status_read_s |=> REG_RDATA == {{(EET_DATA_W-EET_IRQ_W){1'b0}}, $past(status_r)})
        else $error("status read returned wrong data");

    rdata_ctrl_a: assert property (@(posedge CLK) disable iff (RST) // R5
        REG_RD && hit(REG_ADDR, EET_OFS_CTRL) |=> REG_RDATA == {{(EET_DATA_W-1){1'b0}}, $past(both_r)})
        else $error("control read returned wrong data");

    rdata_mask_a: assert property (@(posedge CLK) disable iff (RST)
        REG_RD && hit(REG_ADDR, EET_OFS_MASK) |=> REG_RDATA == {{(EET_DATA_W-EET_IRQ_W){1'b0}}, $past(mask_r)})
        else $error("mask read returned wrong data");

    ctrl_write_a: assert property (@(posedge CLK) disable iff (RST) // R5
        REG_WR && hit(REG_ADDR, EET_OFS_CTRL) |=> both_r == $past(REG_WDATA[EET_CTRL_BOTH]))
        else $error("control write not taken");

    mask_write_a: assert property (@(posedge CLK) disable iff (RST)
        REG_WR && hit(REG_ADDR, EET_OFS_MASK) |=> mask_r == $past(REG_WDATA[EET_IRQ_W-1:0]))
        else $error("mask write not taken");

    // Status and interrupt checks
    status_clear_a: assert property (@(posedge CLK) disable iff (RST)
        status_read_s ##0 (event_vec == EET_IRQ_RST) |=> status_r == EET_IRQ_RST)
        else $error("status not cleared by its read");

    status_count_a: assert property (@(posedge CLK) disable iff (RST) // R8
        taken_err_s ##0 (tally_r != EET_TALLY_MAX) |=> status_r[EET_IRQ_COUNT])
        else $error("count event lost from status");

    status_capture_a: assert property (@(posedge CLK) disable iff (RST) // R1
        capture |=> status_r[EET_IRQ_CAPTURE])
        else $error("capture event lost from status");

    status_sat_a: assert property (@(posedge CLK) disable iff (RST) // R9
        sat_hit |=> status_r[EET_IRQ_SAT] && tally_r == EET_TALLY_MAX)
        else $error("saturation event lost from status");

    irq_level_a: assert property (@(posedge CLK) disable iff (RST)
        1'b1 |=> IRQ == |(status_r & $past(mask_r)))
        else $error("interrupt level disagrees with status and mask");

    irq_masked_a: assert property (@(posedge CLK) disable iff (RST)
        mask_r == EET_IRQ_RST |=> !IRQ)
        else $error("interrupt raised with every source masked");

    // Trap and tally detail checks
    trap_unit_a: assert property (@(posedge CLK) disable iff (RST) // R11
        trap_r[EET_UNIT_LSB-1:0] == '0)
        else $error("trap holds an address inside a unit");

    trap_empty_a: assert property (@(posedge CLK) disable iff (RST) // R4
        !trap_full_r |-> trap_r == EET_TRAP_RST)
        else $error("empty trap holds an address");

    trap_clear_wins_a: assert property (@(posedge CLK) disable iff (RST) // R4
        CLEAR_ECC_STATUS && capture |=> !trap_full_r)
        else $error("capture won over a clear");

    trap_2bit_a: assert property (@(posedge CLK) disable iff (RST) // R5
        READ_ACTIVE && UNIT_ERR && UNIT_ERR_2BIT && !both_r && !CLEAR_ECC_STATUS
        |=> $stable(trap_full_r) && $stable(trap_r))
        else $error("filtered double-bit error reached the trap");

    tally_both_a: assert property (@(posedge CLK) disable iff (RST) // R5
        READ_ACTIVE && UNIT_ERR && UNIT_ERR_2BIT && both_r && tally_r != EET_TALLY_MAX
        |=> tally_r == $past(tally_r) + EET_TALLY_ONE)
        else $error("double-bit error not counted while selected");

    tally_no_err_a: assert property (@(posedge CLK) disable iff (RST) // R8
        !(READ_ACTIVE && UNIT_ERR) |=> $stable(tally_r))
        else $error("tally moved with no errored unit");

    tally_clear_keep_a: assert property (@(posedge CLK) disable iff (RST) // R6
        CLEAR_ECC_STATUS && !READ_ACTIVE |=> $stable(tally_r))
        else $error("clear changed the tally");

endmodule

//--- verification/eet_host_model.sv
// Purpose: Host side model issuing array reads with error flags and clears
// Assumes: Changes land right after a rising clk edge
// Notes:   Idle address and type lines toggle so stale values never look valid
`timescale 1ns/1ps
module eet_host_model (
    input  wire logic        clk,
    output logic             read_active,
    output logic             unit_err,
    output logic             unit_err_2bit,
    output logic [31:0]      unit_addr,
    output logic             clear_ecc_status
);
    initial begin
        {read_active, unit_err, unit_err_2bit, clear_ecc_status, unit_addr} = '0;
    end
    task automatic ev(input logic rd, input logic two, input logic [31:0] a);
        @(posedge clk);
        read_active   <= rd;
        unit_err      <= 1'b1;
        unit_err_2bit <= two;
        unit_addr     <= a;
    endtask
    task automatic idle(input logic clr);
        @(posedge clk);
        read_active      <= 1'b0;
        unit_err         <= 1'b0;
        unit_err_2bit    <= ~unit_err_2bit;
        unit_addr        <= ~unit_addr;
        clear_ecc_status <= clr;
        @(posedge clk);
        clear_ecc_status <= 1'b0;
    endtask
endmodule

//--- verification/tb.sv
// Purpose: Self-checking bench for the fault trap and error tally
// Assumes: Host model drives the error path, bench drives registers
// Notes:   Saturation run is long but stays below the cycle ceiling
`timescale 1ns/1ps
module tb;
    import eet_pkg::*;
    logic        CLK = 1'b0;
    logic        RST = 1'b1;
    logic [7:0]  REG_ADDR = '0;
    logic [31:0] REG_WDATA = '0;
    logic        REG_WR = 1'b0;
    logic        REG_RD = 1'b0;
    logic [31:0] REG_RDATA, ua, trap_e = '0;
    logic        IRQ, ra, ue, u2, cl, cap_e = 1'b0, both_e = 1'b1;
    logic [15:0] tally_e = '0;
    int          mismatches = 0, check_count = 0, cyc = 0;
    initial forever #2 CLK = ~CLK;
    eet_host_model i_host (.clk(CLK), .read_active(ra), .unit_err(ue), .unit_err_2bit(u2),
                           .unit_addr(ua), .clear_ecc_status(cl));
    eet_trap_tally i_dut (.CLK(CLK), .RST(RST), .READ_ACTIVE(ra), .UNIT_ERR(ue), .UNIT_ERR_2BIT(u2),
                          .UNIT_ADDR(ua), .CLEAR_ECC_STATUS(cl), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
                          .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .IRQ(IRQ));
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            mismatches = mismatches + 1;
            stop_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        REG_WR    <= 1'b1;
        REG_ADDR  <= a;
        REG_WDATA <= d;
        @(posedge CLK);
        REG_WR    <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        @(posedge CLK);
        REG_RD   <= 1'b1;
        REG_ADDR <= a;
        @(posedge CLK);
        REG_RD   <= 1'b0;
        #1 chk(REG_RDATA, e);
    endtask
    // Only counted errors move the expected trap and tally
    task automatic err(input logic rd, input logic two, input logic [31:0] a);
        i_host.ev(rd, two, a);
        if (rd && (both_e || !two)) begin
            if (tally_e != 16'hffff) tally_e = tally_e + 16'h0001;
            if (!cap_e) trap_e = {a[31:4], 4'h0};
            cap_e = 1'b1;
        end
    endtask
    initial begin
        logic [31:0] a;
        a = $urandom(3571);
        repeat (4) @(posedge CLK);
        RST <= 1'b0;
        rchk(EET_OFS_TRAP, 32'h0);
        rchk(EET_OFS_TALLY, 32'h0);
        rchk(8'h40, EET_RD_UNMAPPED);
        $display("reset test done");
        for (int i = 0; i < 40; i++) begin
            a = $urandom();
            err(a[0], a[1], a);
        end
        i_host.idle(1'b0);
        rchk(EET_OFS_TRAP, trap_e);
        rchk(EET_OFS_TALLY, {16'h0, tally_e});
        chk({31'h0, IRQ}, 32'h0);
        wr(EET_OFS_TRAP, 32'hffff_fff0);
        wr(EET_OFS_TALLY, 32'h1234);
        rchk(EET_OFS_TRAP, trap_e);
        rchk(EET_OFS_TALLY, {16'h0, tally_e});
        $display("random error test done");
        i_host.idle(1'b1);
        cap_e = 1'b0;
        wr(EET_OFS_CTRL, 32'h0);
        rchk(EET_OFS_CTRL, 32'h0);
        both_e = 1'b0;
        err(1'b1, 1'b1, 32'habcd_0123);
        err(1'b1, 1'b0, 32'h0000_567f);
        i_host.idle(1'b0);
        rchk(EET_OFS_TRAP, 32'h0000_5670);
        rchk(EET_OFS_TALLY, {16'h0, tally_e});
        rchk(EET_OFS_STATUS, 32'h3);
        rchk(EET_OFS_STATUS, 32'h0);
        $display("clear and filter test done");
        wr(EET_OFS_MASK, 32'h1);
        i_host.idle(1'b1);
        cap_e = 1'b0;
        err(1'b1, 1'b1, 32'h0);
        i_host.idle(1'b0);
        #1 chk({31'h0, IRQ}, 32'h0);
        err(1'b1, 1'b0, 32'h0);
        i_host.idle(1'b0);
        #1 chk({31'h0, IRQ}, 32'h1);
        rchk(EET_OFS_STATUS, 32'h2 | {31'h0, cap_e});
        @(posedge CLK);
        #1 chk({31'h0, IRQ}, 32'h0);
        $display("interrupt test done");
        repeat (65536) err(1'b1, 1'b0, 32'h0);
        i_host.idle(1'b0);
        rchk(EET_OFS_TALLY, 32'h0000_ffff);
        rchk(EET_OFS_STATUS, 32'h6);
        chk({16'h0, tally_e}, 32'h0000_ffff);
        @(posedge CLK);
        RST <= 1'b1;
        @(posedge CLK);
        RST <= 1'b0;
        rchk(EET_OFS_TALLY, 32'h0);
        rchk(EET_OFS_TRAP, 32'h0);
        $display("saturation test done");
        stop_test();
    end
endmodule
